// ===== sbtc_checker.sv
// Port-level checks of the timer block
module sbtc_checker
	import sbtc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Pins and events
	input wire logic        osc_input_pin_oe,
	input wire logic        osc_output_pin_oe,
	input wire logic        compare_output,
	input wire logic        conversion_start,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Pins, compare output and trigger pulse
	a_osc_pins_in: assert property (!osc_input_pin_oe && !osc_output_pin_oe)
		else $error("oscillator pin driven");
	a_cmp_pin_idle: assert property (!compare_output)
		else $error("compare pin moved");
	a_conv_one_cycle: assert property (conversion_start |=> !conversion_start)
		else $error("trigger pulse too long");
	// Register bus timing
	a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read not answered");
	a_rdata_hold: assert property ((s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("read data dropped");
	a_bresp_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
		else $error("write response dropped");
	a_write_refuse: assert property (s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
		else $error("write taken while busy");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	// Main scenarios
	c_irq: cover property ($rose(irq));
	c_conv: cover property (conversion_start);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == SBTC_RESP_SLVERR);
endmodule

// ===== sbtc_ext_src.sv
// External count source: bursts of rising edges, pin low between bursts
module sbtc_ext_src (
	// Clock and reset
	input wire logic       clk,
	input wire logic       arst_n,
	// Burst request
	input wire logic       go,
	input wire logic [3:0] edges,
	// Pin and status
	output logic           pin,
	output logic           busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left_ff;
	logic [2:0] ph_ff;
	// Eight-cycle square wave, one rising edge per period
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			left_ff <= 4'h0;
			ph_ff <= 3'h0;
		end else if (go && left_ff == 4'h0) begin
			left_ff <= edges;
			ph_ff <= 3'h0;
		end else if (left_ff != 4'h0) begin
			ph_ff <= ph_ff + 3'h1;
			if (ph_ff == 3'h7) begin
				left_ff <= left_ff - 4'h1;
			end
		end
	end
	// Pin output
	assign pin = (left_ff != 4'h0) && ph_ff[2];
	assign busy = left_ff != 4'h0;
endmodule

// ===== sbtc_pkg.sv
package sbtc_pkg;

	// Register byte addresses
	localparam logic [7:0] SBTC_ADDR_COUNT_LOW   = 8'h00;
	localparam logic [7:0] SBTC_ADDR_COUNT_HIGH  = 8'h04;
	localparam logic [7:0] SBTC_ADDR_FLAG        = 8'h08;
	localparam logic [7:0] SBTC_ADDR_CONTROL     = 8'h10;
	localparam logic [7:0] SBTC_ADDR_CMP_LOW     = 8'h14;
	localparam logic [7:0] SBTC_ADDR_CMP_HIGH    = 8'h18;
	localparam logic [7:0] SBTC_ADDR_CMP_MODE    = 8'h1C;
	localparam logic [7:0] SBTC_ADDR_ENABLE      = 8'h8C;

	// Field positions
	localparam int SBTC_BIT_OVF      = 0;
	localparam int SBTC_BIT_CMP      = 2;
	localparam int SBTC_BIT_ON       = 0;
	localparam int SBTC_BIT_CS       = 1;
	localparam int SBTC_BIT_SYNC_N   = 2;
	localparam int SBTC_BIT_OSC_EN   = 3;
	localparam int SBTC_BIT_PS_LO    = 4;

	// Implemented bit masks and reset values
	localparam logic [7:0]  SBTC_CTRL_MASK   = 8'h3F;
	localparam logic [7:0]  SBTC_FLAG_MASK   = 8'h05;
	localparam logic [7:0]  SBTC_CTRL_RST    = 8'h00;
	localparam logic [7:0]  SBTC_FLAG_RST    = 8'h00;
	localparam logic [7:0]  SBTC_ENABLE_RST  = 8'h00;
	localparam logic [15:0] SBTC_COUNT_RST   = 16'h0000;
	localparam logic [15:0] SBTC_COUNT_MAX   = 16'hFFFF;
	localparam logic [15:0] SBTC_CMP_RST     = 16'h0000;
	localparam logic [2:0]  SBTC_PS_RST      = 3'h0;

	// AXI responses
	localparam logic [1:0] SBTC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SBTC_RESP_SLVERR = 2'h2;

	// Compare modes
	typedef enum logic [1:0] {
		SBTC_CMP_OFF   = 2'h0,
		SBTC_CMP_SWIRQ = 2'h1,
		SBTC_CMP_SPEV  = 2'h2
	} sbtc_cmp_mode_e;

	// Timer control fields
	typedef struct packed {
		logic [1:0] ps;
		logic       osc_en;
		logic       sync_n;
		logic       cs;
		logic       on;
	} sbtc_ctrl_s;

endpackage

// ===== sbtc_sync3.sv
// Three-stage pin synchroniser; stage one feeds stage two only
module sbtc_sync3
	import sbtc_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Pin and synchronised stages
	input  wire logic pin,
	output logic      stage2,
	output logic      stage3
);

	logic stage1_ff;
	logic stage2_ff;
	logic stage3_ff;

	// Shift chain
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1_ff <= 1'b0;
			stage2_ff <= 1'b0;
			stage3_ff <= 1'b0;
		end else begin
			stage1_ff <= pin;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	assign stage2 = stage2_ff;
	assign stage3 = stage3_ff;

endmodule

// ===== sbtc_top.sv
// Sixteen-bit timer/counter with prescaler, compare coupling and AXI4-Lite registers
//
// The AXI4-Lite register port was left to the implementer.
module sbtc_top
	import sbtc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// External count clock pin
	input  wire logic        external_count_clock,
	// Oscillator control and pin enables
	output logic             osc_run,
	output logic             osc_input_pin_oe,
	output logic             osc_output_pin_oe,
	// Compare unit coupling
	input  wire logic        timer_reset_req,
	output logic             compare_output,
	output logic             conversion_start,
	// Interrupt
	output logic             irq
);

	// Registers
	sbtc_ctrl_s  ctrl_ff;
	logic [7:0]  flag_ff;
	logic [7:0]  enable_ff;
	logic [15:0] count_ff;
	logic [15:0] cmp_ff;
	sbtc_cmp_mode_e cmp_mode_ff;
	logic [2:0]  ps_cnt_ff;
	logic        ext_level_ff;
	logic        eq_prev_ff;
	logic        conv_ff;

	// Bus state
	logic        aw_have_ff;
	logic        w_have_ff;
	logic [7:0]  aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;

	// Combinational terms
	logic        ext_s2;
	logic        ext_s3;
	logic        ext_edge;
	logic        src_tick;
	logic        tick;
	logic [2:0]  ps_limit;
	logic        eq_now;
	logic        match;
	logic        spev_clear;
	logic        wr_fire;
	logic [7:0]  wr_byte;
	logic        wr_en;
	logic [7:0]  nxt_flag;
	logic [7:0]  flag_set;
	logic [7:0]  flag_clr;
	logic [15:0] nxt_count;
	logic [7:0]  nxt_ctrl_byte;

	// Register decode, shared by the read and write paths
	function automatic logic addr_known(input logic [7:0] a);
		case (a)
			SBTC_ADDR_COUNT_LOW, SBTC_ADDR_COUNT_HIGH, SBTC_ADDR_FLAG, SBTC_ADDR_CONTROL,
			SBTC_ADDR_CMP_LOW, SBTC_ADDR_CMP_HIGH, SBTC_ADDR_CMP_MODE, SBTC_ADDR_ENABLE: addr_known = 1'b1;
			default: addr_known = 1'b0;
		endcase
	endfunction

	// External pin synchroniser
	sbtc_sync3 u_ext_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.pin    (external_count_clock),
		.stage2 (ext_s2),
		.stage3 (ext_s3)
	);

	// Filtered level, follows the pin once stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_level_ff <= 1'b0;
		end else if (ext_s2 == ext_s3) begin
			ext_level_ff <= ext_s3;
		end
	end

	// Rising edge of the external clock, filtered or raw
	always_comb begin
		if (ctrl_ff.sync_n) begin
			ext_edge = ext_s2 & ~ext_s3;
		end else begin
			ext_edge = ext_s2 & ext_s3 & ~ext_level_ff;
		end
	end

	// Clock source; every device clock is one instruction cycle
	assign src_tick = ctrl_ff.cs ? ext_edge : 1'b1;
	assign ps_limit = 3'((4'h1 << ctrl_ff.ps) - 4'h1);
	assign tick     = ctrl_ff.on & src_tick & (ps_cnt_ff == ps_limit);

	// Prescaler, cleared when the timer is off
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ps_cnt_ff <= SBTC_PS_RST;
		end else if (!ctrl_ff.on) begin
			ps_cnt_ff <= SBTC_PS_RST;
		end else if (src_tick) begin
			ps_cnt_ff <= (ps_cnt_ff == ps_limit) ? SBTC_PS_RST : 3'(ps_cnt_ff + 3'h1);
		end
	end

	// Compare match on the rising edge of equality
	assign eq_now     = (count_ff == cmp_ff);
	assign match      = eq_now & ~eq_prev_ff & (cmp_mode_ff != SBTC_CMP_OFF);
	assign spev_clear = match & (cmp_mode_ff == SBTC_CMP_SPEV);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eq_prev_ff <= 1'b0;
		end else begin
			eq_prev_ff <= eq_now;
		end
	end

	// Conversion start pulse on a special event
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_ff <= 1'b0;
		end else begin
			conv_ff <= spev_clear;
		end
	end

	// Write strobe from the bus
	assign wr_fire = aw_have_ff & w_have_ff & ~bvalid_ff;
	assign wr_byte = w_data_ff[7:0];
	assign wr_en   = wr_fire & w_strb_ff[0];

	// Counter: compare reset, then write, then increment
	always_comb begin
		nxt_count = count_ff;
		if (timer_reset_req || spev_clear) begin
			nxt_count = SBTC_COUNT_RST;
		end else if (wr_en && aw_addr_ff == SBTC_ADDR_COUNT_LOW) begin
			nxt_count = {count_ff[15:8], wr_byte};
		end else if (wr_en && aw_addr_ff == SBTC_ADDR_COUNT_HIGH) begin
			nxt_count = {wr_byte, count_ff[7:0]};
		end else if (tick) begin
			nxt_count = 16'(count_ff + 16'h0001);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_ff <= SBTC_COUNT_RST;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Flag set and clear; a set in the clear cycle survives
	always_comb begin
		flag_set = 8'h00;
		flag_set[SBTC_BIT_OVF] = tick & (count_ff == SBTC_COUNT_MAX) & ~spev_clear & ~timer_reset_req;
		flag_set[SBTC_BIT_CMP] = match;
		flag_clr = 8'h00;
		if (wr_en && aw_addr_ff == SBTC_ADDR_FLAG) begin
			flag_clr = wr_byte & SBTC_FLAG_MASK;
		end
		nxt_flag = (flag_ff & ~flag_clr) | flag_set;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_ff <= SBTC_FLAG_RST;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	// Control register; top two bits are not stored
	assign nxt_ctrl_byte = wr_byte & SBTC_CTRL_MASK;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= sbtc_ctrl_s'(SBTC_CTRL_RST[5:0]);
		end else if (wr_en && aw_addr_ff == SBTC_ADDR_CONTROL) begin
			ctrl_ff <= sbtc_ctrl_s'(nxt_ctrl_byte[5:0]);
		end
	end

	// Enable register gates the flags
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_ff <= SBTC_ENABLE_RST;
		end else if (wr_en && aw_addr_ff == SBTC_ADDR_ENABLE) begin
			enable_ff <= wr_byte & SBTC_FLAG_MASK;
		end
	end

	// Compare value and mode
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_ff      <= SBTC_CMP_RST;
			cmp_mode_ff <= SBTC_CMP_OFF;
		end else if (wr_en) begin
			if (aw_addr_ff == SBTC_ADDR_CMP_LOW) begin
				cmp_ff[7:0] <= wr_byte;
			end
			if (aw_addr_ff == SBTC_ADDR_CMP_HIGH) begin
				cmp_ff[15:8] <= wr_byte;
			end
			if (aw_addr_ff == SBTC_ADDR_CMP_MODE) begin
				case (wr_byte[1:0])
					2'h1:    cmp_mode_ff <= SBTC_CMP_SWIRQ;
					2'h2:    cmp_mode_ff <= SBTC_CMP_SPEV;
					default: cmp_mode_ff <= SBTC_CMP_OFF;
				endcase
			end
		end
	end

	// Outputs
	assign irq               = |(flag_ff & enable_ff);
	assign osc_run           = ctrl_ff.osc_en;
	assign osc_input_pin_oe  = 1'b0;
	assign osc_output_pin_oe = 1'b0;
	assign compare_output    = 1'b0; // pin never driven by these modes
	assign conversion_start  = conv_ff;

	// Write address and data are held until both have arrived
	assign s_axi_awready = ~aw_have_ff & ~bvalid_ff;
	assign s_axi_wready  = ~w_have_ff & ~bvalid_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_have_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			w_have_ff <= 1'b0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_ff <= 1'b1;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_ff <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= SBTC_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= addr_known(aw_addr_ff) ? SBTC_RESP_OKAY : SBTC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// Read path, one cycle after the address is taken
	assign s_axi_arready = ~rvalid_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= SBTC_RESP_OKAY;
			rdata_ff  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= addr_known(s_axi_araddr) ? SBTC_RESP_OKAY : SBTC_RESP_SLVERR;
			case (s_axi_araddr)
				SBTC_ADDR_COUNT_LOW:  rdata_ff <= {24'h00_0000, count_ff[7:0]};
				SBTC_ADDR_COUNT_HIGH: rdata_ff <= {24'h00_0000, count_ff[15:8]};
				SBTC_ADDR_FLAG:       rdata_ff <= {24'h00_0000, flag_ff};
				SBTC_ADDR_CONTROL:    rdata_ff <= {26'h000_0000, ctrl_ff};
				SBTC_ADDR_CMP_LOW:    rdata_ff <= {24'h00_0000, cmp_ff[7:0]};
				SBTC_ADDR_CMP_HIGH:   rdata_ff <= {24'h00_0000, cmp_ff[15:8]};
				SBTC_ADDR_CMP_MODE:   rdata_ff <= {30'h0000_0000, cmp_mode_ff};
				SBTC_ADDR_ENABLE:     rdata_ff <= {24'h00_0000, enable_ff};
				default:              rdata_ff <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp  = rresp_ff;
	assign s_axi_rdata  = rdata_ff;

endmodule

// ===== tb_sixteen_bit_timer_counter.sv
// Register-level tests of the timer block
module tb_sixteen_bit_timer_counter;
	import sbtc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        trq = 1'b0;
	logic        go = 1'b0;
	logic [3:0]  edges = 4'h0;
	logic        ext_pin;
	logic        ext_busy;
	logic        s_axi_awready;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        osc_run;
	logic        osc_input_pin_oe;
	logic        osc_output_pin_oe;
	logic        compare_output;
	logic        conversion_start;
	logic        irq;
	logic [31:0] d;
	logic [1:0]  r;
	logic [1:0]  lb;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          hs = 0;
	int          convs = 0;
	int          t0;

	// Clock, cycle count and trigger pulse count
	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	always @(posedge clk) if (conversion_start === 1'b1) convs <= convs + 1;

	sbtc_top i_dut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready),
		.external_count_clock(ext_pin), .osc_run(osc_run), .osc_input_pin_oe(osc_input_pin_oe),
		.osc_output_pin_oe(osc_output_pin_oe), .timer_reset_req(trq), .compare_output(compare_output),
		.conversion_start(conversion_start), .irq(irq));
	sbtc_ext_src i_src (.clk(clk), .arst_n(arst_n), .go(go), .edges(edges), .pin(ext_pin), .busy(ext_busy));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Bus write: address and data offered together, response taken after it shows
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= {24'h00_0000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge clk);
			hs = cyc;
			if (ta) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(negedge clk); while (s_axi_bvalid !== 1'b1);
		lb = s_axi_bresp;
		@(posedge clk);
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
	endtask

	// Bus read
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge clk); while (s_axi_arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge clk);
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, d, e);
	endtask

	task automatic clear_count();
		wr(SBTC_ADDR_COUNT_LOW, 8'h00);
		wr(SBTC_ADDR_COUNT_HIGH, 8'h00);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		close_out();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rc("ctrl_reset", SBTC_ADDR_CONTROL, 32'h0000_0000);
		rc("enable_reset", SBTC_ADDR_ENABLE, 32'h0000_0000);
		rc("flag_reset", SBTC_ADDR_FLAG, 32'h0000_0000);
		rd(8'h40);
		chk("rd_unmapped", 32'(r), 32'(SBTC_RESP_SLVERR));
		wr(8'h40, 8'hFF);
		chk("wr_unmapped", 32'(lb), 32'(SBTC_RESP_SLVERR));
		wr(SBTC_ADDR_CONTROL, 8'hFE);
		rc("ctrl_mask", SBTC_ADDR_CONTROL, 32'h0000_003E);
		chk("osc_on", 32'(osc_run), 32'h0000_0001);
		wr(SBTC_ADDR_CONTROL, 8'h00);
		chk("osc_off", 32'(osc_run), 32'h0000_0000);
		wr(SBTC_ADDR_COUNT_LOW, 8'hFE);
		wr(SBTC_ADDR_COUNT_HIGH, 8'hFF);
		repeat (20) @(posedge clk);
		rc("count_low", SBTC_ADDR_COUNT_LOW, 32'h0000_00FE);
		rc("count_high", SBTC_ADDR_COUNT_HIGH, 32'h0000_00FF);
		wr(SBTC_ADDR_CONTROL, 8'h01);
		repeat (10) @(posedge clk);
		wr(SBTC_ADDR_CONTROL, 8'h00);
		rc("wrap_high", SBTC_ADDR_COUNT_HIGH, 32'h0000_0000);
		rc("ovf_flag", SBTC_ADDR_FLAG, 32'h0000_0001);
		chk("irq_masked", 32'(irq), 32'h0000_0000);
		wr(SBTC_ADDR_ENABLE, 8'h01);
		chk("irq_on", 32'(irq), 32'h0000_0001);
		wr(SBTC_ADDR_ENABLE, 8'h00);
		chk("irq_off", 32'(irq), 32'h0000_0000);
		wr(SBTC_ADDR_FLAG, 8'h01);
		rc("ovf_clear", SBTC_ADDR_FLAG, 32'h0000_0000);
		// Every prescale code over 64 cycles, sync bit set but ignored
		for (int p = 0; p < 4; p++) begin
			clear_count();
			wr(SBTC_ADDR_CONTROL, 8'h05 | 8'(p << 4));
			t0 = hs;
			while (cyc < t0 + 63) @(posedge clk);
			wr(SBTC_ADDR_CONTROL, 8'h00);
			rc("prescale", SBTC_ADDR_COUNT_LOW, 32'h0000_0040 >> p);
		end
		// External edges, synchronised then not
		for (int s = 0; s < 2; s++) begin
			clear_count();
			wr(SBTC_ADDR_CONTROL, 8'h03 | 8'(s << 2));
			go <= 1'b1;
			edges <= 4'h5;
			@(posedge clk);
			go <= 1'b0;
			repeat (50) @(posedge clk);
			wr(SBTC_ADDR_CONTROL, 8'h00);
			rc("ext_edges", SBTC_ADDR_COUNT_LOW, 32'h0000_0005);
		end
		// Reset input from the compare side
		wr(SBTC_ADDR_COUNT_HIGH, 8'h12);
		wr(SBTC_ADDR_COUNT_LOW, 8'h34);
		trq <= 1'b1;
		@(posedge clk);
		trq <= 1'b0;
		rc("rst_low", SBTC_ADDR_COUNT_LOW, 32'h0000_0000);
		rc("rst_high", SBTC_ADDR_COUNT_HIGH, 32'h0000_0000);
		// Special event: period of 0x10, compare used in timer mode
		wr(SBTC_ADDR_CMP_LOW, 8'h10);
		wr(SBTC_ADDR_CMP_HIGH, 8'h00);
		wr(SBTC_ADDR_CMP_MODE, {6'h00, SBTC_CMP_SPEV});
		t0 = convs;
		wr(SBTC_ADDR_CONTROL, 8'h01);
		repeat (60) @(posedge clk);
		wr(SBTC_ADDR_CONTROL, 8'h00);
		chk("conv_seen", 32'(convs > t0), 32'h0000_0001);
		rd(SBTC_ADDR_COUNT_LOW);
		chk("period", 32'(d <= 32'h0000_0010), 32'h0000_0001);
		rc("spev_flags", SBTC_ADDR_FLAG, 32'h0000_0004);
		wr(SBTC_ADDR_FLAG, 8'h05);
		// Software interrupt compare
		wr(SBTC_ADDR_CMP_MODE, {6'h00, SBTC_CMP_SWIRQ});
		wr(SBTC_ADDR_ENABLE, 8'h04);
		clear_count();
		t0 = convs;
		wr(SBTC_ADDR_CONTROL, 8'h01);
		repeat (30) @(posedge clk);
		wr(SBTC_ADDR_CONTROL, 8'h00);
		chk("no_conv", 32'(convs - t0), 32'h0000_0000);
		rc("swi_flag", SBTC_ADDR_FLAG, 32'h0000_0004);
		chk("cmp_irq", 32'(irq), 32'h0000_0001);
		wr(SBTC_ADDR_FLAG, 8'h04);
		chk("cmp_irq_clr", 32'(irq), 32'h0000_0000);
		// Special event at the top of the range: cleared, no overflow flag
		wr(SBTC_ADDR_CMP_MODE, {6'h00, SBTC_CMP_SPEV});
		wr(SBTC_ADDR_CMP_LOW, 8'hFF);
		wr(SBTC_ADDR_CMP_HIGH, 8'hFF);
		wr(SBTC_ADDR_COUNT_HIGH, 8'hFF);
		wr(SBTC_ADDR_COUNT_LOW, 8'hF0);
		t0 = convs;
		wr(SBTC_ADDR_CONTROL, 8'h01);
		repeat (30) @(posedge clk);
		wr(SBTC_ADDR_CONTROL, 8'h00);
		chk("top_conv", 32'(convs - t0), 32'h0000_0001);
		rc("top_flags", SBTC_ADDR_FLAG, 32'h0000_0004);
		rc("top_high", SBTC_ADDR_COUNT_HIGH, 32'h0000_0000);
		// Mode code three leaves compare off
		wr(SBTC_ADDR_CMP_MODE, 8'h03);
		rc("mode_three", SBTC_ADDR_CMP_MODE, 32'h0000_0000);
		close_out();
	end
endmodule

bind sbtc_top sbtc_checker i_chk (.clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .osc_input_pin_oe, .osc_output_pin_oe, .compare_output, .conversion_start, .irq);
